/* design/fpb_regs.svh */
`ifndef FPB_REGS_SVH
`define FPB_REGS_SVH
// register byte offsets (low address byte)
`define FPB_OFS_SCR      8'h00
`define FPB_OFS_EXC      8'h04
`define FPB_OFS_INST     8'h08
`define FPB_OFS_ID       8'h0c
// status/control field positions
`define FPB_DN_BIT       25
`define FPB_FZ_BIT       24
`define FPB_STRIDE_HI    21
`define FPB_STRIDE_LO    20
`define FPB_LEN_HI       18
`define FPB_LEN_LO       16
`define FPB_EX_BIT       15
`define FPB_EN_HI        12
`define FPB_EN_LO        8
`define FPB_IOE_BIT      8
`define FPB_OFE_BIT      10
`define FPB_UFE_BIT      11
`define FPB_IOC_BIT      0
`define FPB_SCR_MASK     32'h0337_9f1f
`define FPB_SCR_RESET    32'h0000_0000
`define FPB_EXC_EX_BIT   31
`define FPB_INST_RESET   32'h0000_0000
// instruction word register fields, five bits each
`define FPB_FD_LSB       12
`define FPB_FN_LSB       16
`define FPB_FM_LSB       0
// exponent limits and potential-exception thresholds
`define FPB_EMAX_S       11'h0ff
`define FPB_EMAX_D       11'h7ff
`define FPB_OVF_SUM_S    12'h17e
`define FPB_OVF_SUM_D    12'hbfe
`define FPB_OVF_MAX_S    11'h0fe
`define FPB_OVF_MAX_D    11'h7fe
`define FPB_UNF_SUM_S    12'h07f
`define FPB_UNF_SUM_D    12'h3ff
`define FPB_CANCEL_S     11'h018
`define FPB_CANCEL_D     11'h035
`define FPB_QBIT_S       22
`define FPB_QBIT_D       51
`define FPB_DNAN_S       64'h0000_0000_7fc0_0000
`define FPB_DNAN_D       64'h7ff8_0000_0000_0000
// short-vector length limits for unlocked sources
`define FPB_HALF_LEN_S   3'h3
`define FPB_HALF_LEN_D   3'h1
`define FPB_STRIDE_TWO   2'h3
`endif

/* design/fpb_pkg.sv */
package fpb_pkg;
	typedef enum logic [2:0] {
		FPB_K_NONE, FPB_K_ARITH, FPB_K_TO_REG, FPB_K_FROM_REG,
		FPB_K_TO_SYS, FPB_K_FROM_SYS, FPB_K_ILLEGAL
	} fpb_kind_t;
	typedef enum logic [1:0] {FPB_SYS_SCR, FPB_SYS_EXC, FPB_SYS_INST, FPB_SYS_ID} fpb_sys_t;
	typedef struct packed {
		logic        valid;
		fpb_kind_t   kind;
		fpb_sys_t    sys;
		logic        dbl;
		logic        divsqrt;
		logic [2:0]  iter;
		logic [31:0] word;
		logic [31:0] host_lo;
		logic [31:0] host_hi;
		logic [63:0] op_a;
		logic [63:0] op_b;
	} fpb_issue_t;
	typedef struct packed {
		logic        coproc_reject_decode;
		logic        accept;
		logic        src_lock;
		logic        xfer_valid;
		logic [63:0] xfer_data;
		logic        nan_valid;
		logic [63:0] nan_result;
		logic [63:0] opa_eff;
		logic [63:0] opb_eff;
	} fpb_resp_t;
	typedef struct packed {
		logic        sign;
		logic [10:0] exp;
		logic        nan;
		logic        snan;
		logic        inf;
		logic        sub;
		logic        zero;
	} fpb_cls_t;
endpackage

/* design/fpb_bounce_ctrl.sv */
// Functional notes
// - bounce is decided in decode and raised toward the host one edge later.
// - a bounced instruction is not acknowledged; host takes undefined trap.
// - default-NaN bit 25 set makes every NaN result the default NaN.
// - flush-to-zero bit 24 turns subnormal inputs into positive zero.
// - disabled exception gives standard result, no report to user handler.
// - enabled exception occurring causes a trap to the user handler.
// - exponents and signs classify an instruction as potentially exceptional.
// - potentially exceptional issue sets exceptional flag, stores instruction copy.
// - short vector copy gets register fields rewritten for the exceptional iteration.
// - in exceptional state the next trigger bounces and does no work.
// - illegal instructions bounce even without pending exception.
// - unsupported operand raises input exception and bounces.
// - fast mode half vectors, not divide/sqrt, leave sources unlocked.
// - vector register addressing wraps within four banks of eight/four registers.
// - reserved control bits are written zero and read as zero.
// - NaN is max exponent, nonzero fraction; fraction MSB zero means signaling.
// - infinity is max exponent with all-zero significand.
// - transfers move 32 or 64 bits between host and coprocessor registers.
// - system transfers to exception, copy or id registers never trigger.
// - fast mode is DN, FZ and no enables; legal operations never bounce.
`timescale 1ns/10ps
`include "fpb_regs.svh"
`default_nettype none
module fpb_bounce_ctrl
	import fpb_pkg::*;
#(
	parameter logic [31:0] ID_VALUE = 32'h0000_5a3c // arbitrary identification value
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire fpb_issue_t  issue,
	output fpb_resp_t        resp
);

////////////////////////////////////////////////////////////////////////////////
function automatic fpb_cls_t classify(input logic [63:0] x, input logic dbl);
	fpb_cls_t c;
	logic     fz;
	logic     qb;
	c = '0;
	if (dbl) begin
		c.sign = x[63];
		c.exp  = x[62:52];
		fz     = (x[51:0] == 52'h0);
		qb     = x[`FPB_QBIT_D];
		c.nan  = (c.exp == `FPB_EMAX_D) && !fz;
		c.inf  = (c.exp == `FPB_EMAX_D) && fz;
	end else begin
		c.sign = x[31];
		c.exp  = {3'h0, x[30:23]};
		fz     = (x[22:0] == 23'h0);
		qb     = x[`FPB_QBIT_S];
		c.nan  = (c.exp == `FPB_EMAX_S) && !fz;
		c.inf  = (c.exp == `FPB_EMAX_S) && fz;
	end
	c.snan = c.nan && !qb;
	c.sub  = (c.exp == 11'h0) && !fz;
	c.zero = (c.exp == 11'h0) && fz;
	return c;
endfunction

// offset within a bank; the bank bits never change so vectors wrap
function automatic logic [4:0] bank_step(input logic [4:0] idx, input logic dbl, input logic [3:0] off);
	logic [4:0] r;
	r = idx;
	if (dbl)
		r[1:0] = idx[1:0] + off[1:0];
	else
		r[2:0] = idx[2:0] + off[2:0];
	return r;
endfunction

function automatic logic [4:0] fld(input logic [31:0] w, input int lsb);
	return w[lsb +: 5];
endfunction

////////////////////////////////////////////////////////////////////////////////
logic [31:0] scr_q;
logic        ex_q;
logic [31:0] inst_q;
logic [31:0] rf_q [32];
logic        wr_pend_q;
logic [7:0]  wa_q;

logic        dn;
logic        fz;
logic        fast;
fpb_cls_t    ca;
fpb_cls_t    cb;
logic        is_arith;
logic        exempt;
logic        trigger;
logic        illegal;
logic        unsup;
logic        snan_trap;
logic        nrm;
logic [11:0] esum;
logic [10:0] emax;
logic [10:0] emin;
logic        ovf_risk;
logic        unf_risk;
logic        pot_exc;
logic        bounce;
logic        take;
logic        halfvec;
logic [3:0]  off;
logic [31:0] inst_d;
logic        ahb_addr;
logic        ahb_wr;
logic        sw_clear;
logic [4:0]  fd;

assign dn   = scr_q[`FPB_DN_BIT];
assign fz   = scr_q[`FPB_FZ_BIT];
assign fast = dn && fz && (scr_q[`FPB_EN_HI:`FPB_EN_LO] == 5'h0);
assign ca   = classify(issue.op_a, issue.dbl);
assign cb   = classify(issue.op_b, issue.dbl);
assign fd   = fld(issue.word, `FPB_FD_LSB);

////////////////////////////////////////////////////////////////////////////////
// issue decode: everything is decided in the decode cycle and answered one edge later
assign is_arith = issue.valid && (issue.kind == FPB_K_ARITH);
assign exempt   = (issue.kind == FPB_K_TO_SYS || issue.kind == FPB_K_FROM_SYS)
	&& (issue.sys != FPB_SYS_SCR);
assign trigger  = issue.valid && ex_q && !exempt;
assign illegal  = issue.valid && (issue.kind == FPB_K_ILLEGAL);
// subnormals need support code unless flushed
assign unsup     = is_arith && !fz && (ca.sub || cb.sub);
assign snan_trap = is_arith && scr_q[`FPB_IOE_BIT] && (ca.snan || cb.snan);
assign nrm  = !(ca.zero || ca.nan || ca.inf || cb.zero || cb.nan || cb.inf);
assign esum = {1'b0, ca.exp} + {1'b0, cb.exp};
assign emax = (ca.exp > cb.exp) ? ca.exp : cb.exp;
assign emin = (ca.exp > cb.exp) ? cb.exp : ca.exp;
always_comb begin
	if (issue.dbl) begin
		ovf_risk = (esum >= `FPB_OVF_SUM_D) || (emax >= `FPB_OVF_MAX_D);
		unf_risk = (esum <= `FPB_UNF_SUM_D) || ((ca.sign != cb.sign) && (emin <= `FPB_CANCEL_D));
	end else begin
		ovf_risk = (esum >= `FPB_OVF_SUM_S) || (emax >= `FPB_OVF_MAX_S);
		unf_risk = (esum <= `FPB_UNF_SUM_S) || ((ca.sign != cb.sign) && (emin <= `FPB_CANCEL_S));
	end
end
// only enabled exceptions enter the exceptional state; disabled ones finish in hardware
assign pot_exc = is_arith && nrm && !trigger && !unsup && !snan_trap
	&& ((scr_q[`FPB_OFE_BIT] && ovf_risk) || (scr_q[`FPB_UFE_BIT] && unf_risk));
assign bounce = trigger || illegal || unsup || snan_trap;
assign take   = issue.valid && !bounce;
assign halfvec = issue.dbl ? (scr_q[`FPB_LEN_HI:`FPB_LEN_LO] <= `FPB_HALF_LEN_D)
	: (scr_q[`FPB_LEN_HI:`FPB_LEN_LO] <= `FPB_HALF_LEN_S);

// rewrite the register fields so the copy names the faulting iteration
assign off = (scr_q[`FPB_STRIDE_HI:`FPB_STRIDE_LO] == `FPB_STRIDE_TWO) ? {issue.iter, 1'b0} : {1'b0, issue.iter};
always_comb begin
	inst_d = issue.word;
	inst_d[`FPB_FD_LSB +: 5] = bank_step(fd, issue.dbl, off);
	inst_d[`FPB_FN_LSB +: 5] = bank_step(fld(issue.word, `FPB_FN_LSB), issue.dbl, off);
	// a source in the first bank stays scalar
	if (issue.dbl ? (fld(issue.word, `FPB_FM_LSB) >= 5'h04) : (fld(issue.word, `FPB_FM_LSB) >= 5'h08))
		inst_d[`FPB_FM_LSB +: 5] = bank_step(fld(issue.word, `FPB_FM_LSB), issue.dbl, off);
end

////////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave, zero wait states
function automatic logic [31:0] rd_sys(input logic [1:0] sel, input logic [31:0] scr, input logic ex,
	input logic [31:0] inst);
	case (sel)
		FPB_SYS_SCR:  return (scr & `FPB_SCR_MASK) | ({31'h0, ex} << `FPB_EX_BIT);
		FPB_SYS_EXC:  return {31'h0, ex} << `FPB_EXC_EX_BIT;
		FPB_SYS_INST: return inst;
		default:      return ID_VALUE;
	endcase
endfunction

assign ahb_addr = hsel && htrans[1] && hready;
assign ahb_wr   = wr_pend_q && ((wa_q == `FPB_OFS_SCR) || (wa_q == `FPB_OFS_EXC));
assign sw_clear = (ahb_wr && (wa_q == `FPB_OFS_SCR) && !hwdata[`FPB_EX_BIT])
	|| (ahb_wr && (wa_q == `FPB_OFS_EXC) && !hwdata[`FPB_EXC_EX_BIT])
	|| (take && issue.kind == FPB_K_TO_SYS && issue.sys == FPB_SYS_EXC && !issue.host_lo[`FPB_EXC_EX_BIT]);

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_q <= 1'b0;
		wa_q      <= 8'h00;
	end else begin
		wr_pend_q <= ahb_addr && hwrite && (hsize == 3'h2);
		if (ahb_addr)
			wa_q <= haddr[7:0];
	end
end

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata    <= 32'h0;
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
	end else begin
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
		if (ahb_addr && !hwrite) begin
			case (haddr[7:0])
				`FPB_OFS_SCR:  hrdata <= rd_sys(FPB_SYS_SCR, scr_q, ex_q, inst_q);
				`FPB_OFS_EXC:  hrdata <= rd_sys(FPB_SYS_EXC, scr_q, ex_q, inst_q);
				`FPB_OFS_INST: hrdata <= rd_sys(FPB_SYS_INST, scr_q, ex_q, inst_q);
				`FPB_OFS_ID:   hrdata <= rd_sys(FPB_SYS_ID, scr_q, ex_q, inst_q);
				default:       hrdata <= 32'h0;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control registers
always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		scr_q <= `FPB_SCR_RESET;
	end else begin
		if (take && issue.kind == FPB_K_TO_SYS && issue.sys == FPB_SYS_SCR)
			scr_q <= issue.host_lo & `FPB_SCR_MASK & ~(32'h1 << `FPB_EX_BIT);
		if (ahb_wr && wa_q == `FPB_OFS_SCR)
			scr_q <= hwdata & `FPB_SCR_MASK & ~(32'h1 << `FPB_EX_BIT);
		// sticky invalid flag: hardware set wins over a clearing write
		if (take && is_arith && (ca.snan || cb.snan))
			scr_q[`FPB_IOC_BIT] <= 1'b1;
	end
end

// set wins over the clear, so an exception in the clearing cycle is kept
always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		ex_q <= 1'b0;
	else if (pot_exc)
		ex_q <= 1'b1;
	else if (sw_clear)
		ex_q <= 1'b0;
end

always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn)
		inst_q <= `FPB_INST_RESET;
	else if (pot_exc)
		inst_q <= inst_d;
end

// data registers carry no reset; they are software state only
always_ff @(posedge hclk) begin
	if (take && issue.kind == FPB_K_TO_REG) begin
		if (issue.dbl) begin
			rf_q[{fd[3:0], 1'b0}] <= issue.host_lo;
			rf_q[{fd[3:0], 1'b1}] <= issue.host_hi;
		end else begin
			rf_q[fd] <= issue.host_lo;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// answer to the host, one edge after decode
always_ff @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		resp <= '0;
	end else begin
		resp.coproc_reject_decode <= bounce;
		resp.accept     <= take;
		resp.src_lock   <= take && is_arith && !(fast && halfvec && !issue.divsqrt);
		resp.xfer_valid <= take && (issue.kind == FPB_K_FROM_REG || issue.kind == FPB_K_FROM_SYS);
		if (issue.kind == FPB_K_FROM_SYS)
			resp.xfer_data <= {32'h0, rd_sys(issue.sys, scr_q, ex_q, inst_q)};
		else if (issue.dbl)
			resp.xfer_data <= {rf_q[{fd[3:0], 1'b1}], rf_q[{fd[3:0], 1'b0}]};
		else
			resp.xfer_data <= {32'h0, rf_q[fd]};
		resp.nan_valid <= take && is_arith && (ca.nan || cb.nan);
		if (dn)
			resp.nan_result <= issue.dbl ? `FPB_DNAN_D : `FPB_DNAN_S;
		else if (issue.dbl)
			resp.nan_result <= (ca.nan ? issue.op_a : issue.op_b) | (64'h1 << `FPB_QBIT_D);
		else
			resp.nan_result <= {32'h0, (ca.nan ? issue.op_a[31:0] : issue.op_b[31:0]) | (32'h1 << `FPB_QBIT_S)};
		resp.opa_eff <= (fz && ca.sub) ? 64'h0 : issue.op_a;
		resp.opb_eff <= (fz && cb.sub) ? 64'h0 : issue.op_b;
	end
end

////////////////////////////////////////////////////////////////////////////////
default clocking cb_dflt @(posedge hclk); endclocking
default disable iff (!hresetn);

chk_trigger_bounce: assert property (issue.valid && ex_q && !exempt |=> resp.coproc_reject_decode && !resp.accept)
	else $error("trigger in exceptional state not bounced");
chk_exempt_pass: assert property (issue.valid && ex_q && exempt |=> !resp.coproc_reject_decode && resp.accept)
	else $error("exempt system transfer bounced");
chk_illegal_bounce: assert property (illegal |=> resp.coproc_reject_decode)
	else $error("illegal instruction not bounced");
chk_ex_capture: assert property (pot_exc && issue.iter == 3'h0 |=> ex_q && inst_q == $past(issue.word))
	else $error("exceptional state or copy not captured");
chk_ex_sticky: assert property (ex_q && !sw_clear |=> ex_q)
	else $error("exceptional flag dropped without software clear");
chk_fast_nobounce: assert property (fast && issue.valid && !illegal && !ex_q |=> !resp.coproc_reject_decode)
	else $error("legal operation bounced in fast mode");
chk_dn_result: assert property (dn && is_arith && !issue.dbl && ca.nan |=> resp.nan_result == `FPB_DNAN_S)
	else $error("default NaN not returned");
chk_fz_flush: assert property (fz && is_arith && ca.sub |=> resp.opa_eff == 64'h0)
	else $error("subnormal input not flushed");
chk_unsup_bounce: assert property (unsup |=> resp.coproc_reject_decode && !resp.accept)
	else $error("unsupported operand not bounced");
chk_halfvec_unlock: assert property (take && is_arith && fast && halfvec && !issue.divsqrt |=> !resp.src_lock)
	else $error("half vector locked its sources");
chk_reserved_zero: assert property ((hrdata & ~(`FPB_SCR_MASK | (32'h1 << `FPB_EX_BIT))) == 32'h0
	|| $past(haddr[7:0]) != `FPB_OFS_SCR || !$past(ahb_addr && !hwrite))
	else $error("reserved status bits read nonzero");
chk_bounce_noack: assert property (resp.coproc_reject_decode |-> !resp.accept && !resp.xfer_valid)
	else $error("bounced instruction acknowledged");

endmodule // fpb_bounce_ctrl
`default_nettype wire

/* tb/fpb_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fpb_host_model
	import fpb_pkg::*;
(
	input  wire logic      hclk,
	input  wire fpb_resp_t resp,
	output fpb_issue_t     issue
);
	int trap_cnt;

	initial begin
		issue = '0;
		trap_cnt = 0;
	end

	// one decode slot per call; released fields show the inverse so stale data never looks valid
	task automatic send(input fpb_issue_t x, output fpb_resp_t r);
		fpb_issue_t idle;
		idle = ~x;
		idle.valid = 1'b0;
		@(posedge hclk);
		issue <= x;
		@(posedge hclk);
		issue <= idle;
		#1 r = resp;
		if (r.coproc_reject_decode === 1'b1 && r.accept !== 1'b1)
			trap_cnt++;
	endtask
endmodule // fpb_host_model
`default_nettype wire

/* tb/fp_coprocessor_bounce_control_test.sv */
`timescale 1ns/10ps
`include "fpb_regs.svh"
`default_nettype none
module fp_coprocessor_bounce_control_test
	import fpb_pkg::*;
;
	localparam logic [31:0] ID_EXP = 32'h0000_1234; // arbitrary identification value
	localparam logic [63:0] ONE_S  = 64'h0000_0000_3f80_0000;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	fpb_issue_t  issue, x;
	fpb_resp_t   resp, r;
	int          error_cnt, comparisons;

	fpb_bounce_ctrl #(.ID_VALUE(ID_EXP)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue(issue), .resp(resp));
	fpb_host_model host (.hclk(hclk), .resp(resp), .issue(issue));

	always #2.5 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize;
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// single word transfer; waits are cut only by the watchdog
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask

	function automatic fpb_issue_t mk(input fpb_kind_t k, input logic [63:0] a, input logic [63:0] b);
		fpb_issue_t v;
		v = '0;
		v.valid = 1'b1;
		v.kind = k;
		v.op_a = a;
		v.op_b = b;
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0]  a [5];
		logic [31:0] e [5];
		a = '{`FPB_OFS_SCR, `FPB_OFS_EXC, `FPB_OFS_INST, `FPB_OFS_ID, 8'h10};
		e = '{32'h0, 32'h0, 32'h0, ID_EXP, 32'h0};
		for (int i = 0; i < 5; i++) begin
			ahb(1'b0, a[i], 32'h0, rd);
			cmp("reg_reset", {32'h0, e[i]}, {32'h0, rd});
			cmp("hresp_okay", 64'h0, {63'h0, hresp});
		end
		ahb(1'b1, `FPB_OFS_SCR, 32'h0337_9f1f, rd);
		ahb(1'b0, `FPB_OFS_SCR, 32'h0, rd);
		cmp("scr_rw", 64'h0337_1f1f, {32'h0, rd});
		ahb(1'b1, `FPB_OFS_SCR, 32'h0, rd);
	endtask

	task automatic t_bounce;
		host.send(mk(FPB_K_ILLEGAL, 64'h0, 64'h0), r);
		cmp("illegal_bounce", 64'h1, {63'h0, r.coproc_reject_decode});
		cmp("illegal_ack", 64'h0, {63'h0, r.accept});
		host.send(mk(FPB_K_ARITH, 64'h8000_0001, ONE_S), r);
		cmp("subn_bounce", 64'h1, {63'h0, r.coproc_reject_decode});
		cmp("traps", 64'h2, 64'(host.trap_cnt));
		ahb(1'b1, `FPB_OFS_SCR, 32'h0100_0000, rd);
		host.send(mk(FPB_K_ARITH, 64'h8000_0001, ONE_S), r);
		cmp("fz_accept", 64'h1, {63'h0, r.accept});
		cmp("fz_opa", 64'h0, r.opa_eff);
	endtask

	task automatic t_nan;
		ahb(1'b1, `FPB_OFS_SCR, 32'h0200_0000, rd);
		host.send(mk(FPB_K_ARITH, 64'h7f80_0001, ONE_S), r);
		cmp("dn_ack", 64'h1, {63'h0, r.accept});
		cmp("dn_result", `FPB_DNAN_S, r.nan_result);
		ahb(1'b1, `FPB_OFS_SCR, 32'h0, rd);
		host.send(mk(FPB_K_ARITH, 64'h7f80_0001, ONE_S), r);
		cmp("quiet_result", 64'h7fc0_0001, r.nan_result);
		host.send(mk(FPB_K_ARITH, 64'h7f80_0000, ONE_S), r);
		cmp("inf_not_nan", 64'h0, {63'h0, r.nan_valid});
		ahb(1'b1, `FPB_OFS_SCR, 32'h0000_0100, rd);
		host.send(mk(FPB_K_ARITH, 64'h7f80_0001, ONE_S), r);
		cmp("snan_trap", 64'h1, {63'h0, r.coproc_reject_decode});
		ahb(1'b1, `FPB_OFS_SCR, 32'h0, rd);
	endtask

	task automatic t_except;
		ahb(1'b1, `FPB_OFS_SCR, 32'h0000_0400, rd);
		x = mk(FPB_K_ARITH, 64'h7f00_0000, 64'h7f00_0000);
		x.word = 32'h0e01_8a40;
		host.send(x, r);
		cmp("risky_ack", 64'h1, {63'h0, r.accept});
		ahb(1'b0, `FPB_OFS_SCR, 32'h0, rd);
		cmp("ex_flag", 64'h1, {63'h0, rd[15]});
		ahb(1'b0, `FPB_OFS_INST, 32'h0, rd);
		cmp("instr_copy", 64'h0e01_8a40, {32'h0, rd});
		for (int i = 0; i < 2; i++) begin
			host.send(mk(FPB_K_ARITH, ONE_S, ONE_S), r);
			cmp("trigger_bounce", 64'h1, {63'h0, r.coproc_reject_decode});
			cmp("trigger_nowork", 64'h0, {63'h0, r.accept});
		end
		x = mk(FPB_K_TO_SYS, 64'h0, 64'h0);
		x.sys = FPB_SYS_EXC;
		x.host_lo = 32'h8000_0000;
		host.send(x, r);
		cmp("exc_write_pass", 64'h0, {63'h0, r.coproc_reject_decode});
		x.kind = FPB_K_FROM_SYS;
		x.sys = FPB_SYS_INST;
		host.send(x, r);
		cmp("inst_read", 64'h0e01_8a40, {32'h0, r.xfer_data[31:0]});
		x.sys = FPB_SYS_SCR;
		host.send(x, r);
		cmp("scr_read_trigger", 64'h1, {63'h0, r.coproc_reject_decode});
		ahb(1'b1, `FPB_OFS_EXC, 32'h0, rd);
		host.send(mk(FPB_K_ARITH, ONE_S, ONE_S), r);
		cmp("after_clear", 64'h1, {63'h0, r.accept});
		ahb(1'b1, `FPB_OFS_SCR, 32'h0, rd);
	endtask

	task automatic t_fast;
		logic [31:0] scr [4];
		logic        ds  [4];
		logic        lk  [4];
		scr = '{32'h0303_0000, 32'h0303_0000, 32'h0304_0000, 32'h0301_0000};
		ds = '{1'b0, 1'b1, 1'b0, 1'b0};
		lk = '{1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, `FPB_OFS_SCR, scr[i], rd);
			x = mk(FPB_K_ARITH, ONE_S, ONE_S);
			x.divsqrt = ds[i];
			if (i == 3) begin
				x.dbl = 1'b1;
				x.op_a = 64'h3ff0_0000_0000_0000;
				x.op_b = 64'h3ff0_0000_0000_0000;
			end
			host.send(x, r);
			cmp("src_lock", {63'h0, lk[i]}, {63'h0, r.src_lock});
		end
		host.send(mk(FPB_K_ARITH, 64'h8000_0001, 64'h7f80_0001), r);
		cmp("fast_nobounce", 64'h0, {63'h0, r.coproc_reject_decode});
		ahb(1'b1, `FPB_OFS_SCR, 32'h0, rd);
	endtask

	task automatic t_xfer;
		x = mk(FPB_K_TO_REG, 64'h0, 64'h0);
		x.word = 32'h0000_5000;
		x.host_lo = 32'hcafe_0123;
		host.send(x, r);
		cmp("to_reg_ack", 64'h1, {63'h0, r.accept});
		x.kind = FPB_K_FROM_REG;
		host.send(x, r);
		cmp("single_back", 64'hcafe_0123, {32'h0, r.xfer_data[31:0]});
		x = mk(FPB_K_TO_REG, 64'h0, 64'h0);
		x.dbl = 1'b1;
		x.word = 32'h0000_3000;
		x.host_lo = 32'h1111_2222;
		x.host_hi = 32'h3333_4444;
		host.send(x, r);
		x.kind = FPB_K_FROM_REG;
		host.send(x, r);
		cmp("double_back", 64'h3333_4444_1111_2222, r.xfer_data);
		x.dbl = 1'b0;
		x.word = 32'h0000_7000;
		host.send(x, r);
		cmp("bank_alias", 64'h3333_4444, {32'h0, r.xfer_data[31:0]});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		error_cnt = 0;
		comparisons = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_bounce;
		t_nan;
		t_except;
		t_fast;
		t_xfer;
		summarize;
	end

	// roughly 140 cycles of traffic; a hang well past that is a failure
	initial begin
		#50000;
		error_cnt++;
		summarize;
	end
endmodule // fp_coprocessor_bounce_control_test
`default_nettype wire
